/* core/cssp_cfg.svh */
// Purpose: offsets, field positions, reset values of the sync serial port
// Assumes: 32-bit apb, one register per aligned word
// Notes: included by bare name
`ifndef CSSP_CFG_SVH
`define CSSP_CFG_SVH
`define CSSP_OFF_MODE 8'h00
`define CSSP_OFF_CTRL0 8'h04
`define CSSP_OFF_CTRL1 8'h08
`define CSSP_OFF_STEER 8'h0C
`define CSSP_OFF_BRG 8'h10
`define CSSP_OFF_TXBUF 8'h14
`define CSSP_OFF_RXBUF 8'h18
`define CSSP_OFF_IREQ 8'h1C
`define CSSP_MODE_SYNC 3'h1
`define CSSP_MODE_PAR 3'h0
`define CSSP_MODE_EXTCLK 3
`define CSSP_C0_HS_RTS 2
`define CSSP_C0_TXC 3
`define CSSP_C0_HS_OFF 4
`define CSSP_C0_OD 5
`define CSSP_C0_CPL 6
`define CSSP_C0_MSB 7
`define CSSP_C1_TE 0
`define CSSP_C1_TI 1
`define CSSP_C1_RE 2
`define CSSP_ST_DIRA 0
`define CSSP_ST_SEL_LO 4
`define CSSP_RST_MODE 8'h00
`define CSSP_RST_CTRL0 8'h08
`define CSSP_RST_STEER 8'h00
`define CSSP_RST_BRG 8'h00
`define CSSP_LAST_BIT 3'h7
`endif

/* core/cssp_pkg.sv */
// Purpose: types of the sync serial port
// Assumes: nothing
// Notes: state of each core module is one packed struct
package cssp_pkg;
    typedef enum logic [1:0] {
        CSSP_TX_IDLE = 2'b01,
        CSSP_TX_SHIFT = 2'b10
    } cssp_tx_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ctrl0;
        logic te;
        logic ti;
        logic re;
        logic rfull;
        logic overrun_flag;
        logic [7:0] steer;
        logic [7:0] brg;
        logic [7:0] txbuf;
        logic [7:0] txsh;
        cssp_tx_state_t txst;
        logic [2:0] txcnt;
        logic act;
        logic txd;
        logic [7:0] rxsh;
        logic [2:0] rxcnt;
        logic [7:0] rxbuf;
        logic end_of_word_window_d;
        logic ext_d;
        logic tx_ireq;
        logic rx_ireq;
    } cssp_state_t;
endpackage : cssp_pkg

/* core/cssp_brg.sv */
// Purpose: bit rate generator, divides a prescaled tick by divisor+1
// Assumes: src_tick is a one-cycle enable pulse
// Notes: reloads the divisor at each count-through
`timescale 1ns/1ps
`default_nettype none
module cssp_brg #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic src_tick,
    input wire logic [W-1:0] div,
    // divided tick
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } cssp_brg_st_t;

    cssp_brg_st_t s_r;
    cssp_brg_st_t s_nxt;

    assign tick = run && src_tick && (s_r.cnt == '0);

    always_comb begin
        s_nxt = s_r;
        if (!run) begin
            s_nxt.cnt = div;
        end else if (src_tick) begin
            // reload keeps the period steady without software help
            s_nxt.cnt = (s_r.cnt == '0) ? div : s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : cssp_brg
`default_nettype wire

/* core/cssp_port.sv */
// Purpose: one channel of a clock-synchronous serial port on apb
// Assumes: pin inputs synchronous to pclk; prescaled ticks are pulses
// Notes: CHANNEL 0 has clock steering, CHANNEL 2 has fixed format
`timescale 1ns/1ps
`default_nettype none
`include "cssp_cfg.svh"
module cssp_port
    import cssp_pkg::*;
#(
    parameter int CHANNEL = 0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // prescaled clock ticks, chosen by control 0 bits 1:0
    input wire logic [3:0] prescaled_clock,
    // serial data
    output logic txd_o,
    output logic txd_oe,
    input wire logic rxd_i,
    // shift clock pins
    input wire logic main_clock_pin_i,
    output logic main_clock_pin_o,
    output logic main_clock_pin_oe,
    output logic alt_clock_pin_a_o,
    output logic alt_clock_pin_a_oe,
    output logic alt_clock_pin_b_o,
    output logic alt_clock_pin_b_oe,
    // handshake pin
    input wire logic cts_n_i,
    output logic rts_n_o,
    output logic rts_oe,
    // interrupt requests
    output logic tx_irq,
    output logic rx_irq
);
    localparam bit CH0 = (CHANNEL == 0);
    localparam bit CH2 = (CHANNEL == 2);

    cssp_state_t s_r;
    cssp_state_t s_nxt;

    logic sync_en;
    logic ext_clk;
    logic clock_polarity_bit;
    logic idle_lvl;
    logic msb_first;
    logic hs_on;
    logic rts_mode;
    logic cts_ok;
    logic busy;
    logic end_of_word_window;
    logic brg_tick;
    logic lead;
    logic trail;
    logic start;
    logic wr;
    logic rd;
    logic txbuf_wr;
    logic rx_done;
    logic sclk;
    logic [1:0] sel;
    logic drive_int;
    logic [7:0] rx_word;

    assign sync_en = (s_r.mode[2:0] == `CSSP_MODE_SYNC);
    assign ext_clk = s_r.mode[`CSSP_MODE_EXTCLK];
    assign clock_polarity_bit = s_r.ctrl0[`CSSP_C0_CPL];
    assign idle_lvl = ~clock_polarity_bit;
    assign msb_first = s_r.ctrl0[`CSSP_C0_MSB];
    assign hs_on = ~s_r.ctrl0[`CSSP_C0_HS_OFF];
    assign rts_mode = s_r.ctrl0[`CSSP_C0_HS_RTS];
    assign cts_ok = !hs_on || rts_mode || !cts_n_i;
    assign busy = (s_r.txst == CSSP_TX_SHIFT);
    assign end_of_word_window = !busy;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign txbuf_wr = wr && (paddr == `CSSP_OFF_TXBUF);
    assign pready = 1'b1;
    assign sel = CH0 ? s_r.steer[`CSSP_ST_SEL_LO +: 2] : 2'b00;
    assign drive_int = sync_en && !ext_clk;

    cssp_brg #(
        .W(8)
    ) u_brg (
        .pclk(pclk),
        .presetn(presetn),
        .run(drive_int),
        .src_tick(prescaled_clock[s_r.ctrl0[1:0]]),
        .div(s_r.brg),
        .tick(brg_tick)
    );

    // one brg tick per half period gives the divide by two
    always_comb begin
        if (ext_clk) begin
            lead = sync_en && (s_r.ext_d == idle_lvl)
                && (main_clock_pin_i != idle_lvl);
            trail = sync_en && (s_r.ext_d != idle_lvl)
                && (main_clock_pin_i == idle_lvl);
        end else begin
            lead = brg_tick && busy && !s_r.act;
            trail = brg_tick && busy && s_r.act;
        end
    end

    // a buffer write in the same cycle would race the load, so wait
    assign start = sync_en && end_of_word_window && s_r.te && !s_r.ti && cts_ok
        && !txbuf_wr;
    assign rx_done = trail && s_r.re && (s_r.rxcnt == `CSSP_LAST_BIT);
    assign rx_word = msb_first ? {s_r.rxsh[6:0], rxd_i}
        : {rxd_i, s_r.rxsh[7:1]};

    always_comb begin
        s_nxt = s_r;
        s_nxt.end_of_word_window_d = end_of_word_window;
        s_nxt.ext_d = main_clock_pin_i;
        if (wr) begin
            case (paddr)
                `CSSP_OFF_MODE: begin
                    s_nxt.mode = pwdata[7:0];
                end
                `CSSP_OFF_CTRL0: begin
                    s_nxt.ctrl0 = {pwdata[7:4], s_r.ctrl0[`CSSP_C0_TXC],
                        pwdata[2:0]};
                    if (CH2) begin
                        s_nxt.ctrl0[7:5] = 3'h0;
                        s_nxt.ctrl0[`CSSP_C0_HS_RTS] = 1'b0;
                    end
                end
                `CSSP_OFF_CTRL1: begin
                    s_nxt.te = pwdata[`CSSP_C1_TE];
                    s_nxt.re = pwdata[`CSSP_C1_RE];
                    if (!pwdata[`CSSP_C1_RE]) begin
                        s_nxt.rfull = 1'b0;
                        s_nxt.overrun_flag = 1'b0;
                    end
                end
                `CSSP_OFF_STEER: begin
                    s_nxt.steer = CH0 ? (pwdata[7:0] & 8'h31) : 8'h00;
                end
                `CSSP_OFF_BRG: begin
                    s_nxt.brg = pwdata[7:0];
                end
                `CSSP_OFF_TXBUF: begin
                    s_nxt.txbuf = pwdata[7:0];
                    s_nxt.ti = 1'b0;
                end
                `CSSP_OFF_IREQ: begin
                    if (pwdata[0]) begin
                        s_nxt.tx_ireq = 1'b0;
                    end
                    if (pwdata[1]) begin
                        s_nxt.rx_ireq = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (rd && paddr == `CSSP_OFF_RXBUF) begin
            s_nxt.rfull = 1'b0;
        end
        if (s_r.mode[2:0] == `CSSP_MODE_PAR) begin
            s_nxt.rfull = 1'b0;
            s_nxt.overrun_flag = 1'b0;
        end
        // hardware events come after software so that sets win
        if (!sync_en) begin
            s_nxt.txst = CSSP_TX_IDLE;
            s_nxt.act = 1'b0;
        end else if (start) begin
            s_nxt.txsh = s_r.txbuf;
            s_nxt.ti = 1'b1;
            s_nxt.tx_ireq = 1'b1;
            s_nxt.txst = CSSP_TX_SHIFT;
            s_nxt.txcnt = 3'h0;
            s_nxt.act = 1'b0;
            s_nxt.ctrl0[`CSSP_C0_TXC] = 1'b0;
        end else if (busy) begin
            // flags and cts are not looked at until the word ends
            if (lead) begin
                s_nxt.txd = msb_first ? s_r.txsh[7] : s_r.txsh[0];
                s_nxt.txsh = msb_first ? {s_r.txsh[6:0], 1'b0}
                    : {1'b0, s_r.txsh[7:1]};
                s_nxt.act = 1'b1;
            end
            if (trail) begin
                s_nxt.act = 1'b0;
                s_nxt.txcnt = s_r.txcnt + 3'h1;
                if (s_r.txcnt == `CSSP_LAST_BIT) begin
                    s_nxt.txst = CSSP_TX_IDLE;
                end
            end
        end
        if (sync_en && !start && end_of_word_window && !s_r.end_of_word_window_d) begin
            s_nxt.ctrl0[`CSSP_C0_TXC] = 1'b1;
        end
        if (!s_r.re) begin
            s_nxt.rxcnt = 3'h0;
        end else if (trail) begin
            s_nxt.rxsh = rx_word;
            s_nxt.rxcnt = s_r.rxcnt + 3'h1;
        end
        if (rx_done) begin
            s_nxt.rxbuf = rx_word;
            s_nxt.rfull = 1'b1;
            if (s_r.rfull) begin
                s_nxt.overrun_flag = 1'b1;
            end else if (CH2) begin
                s_nxt.tx_ireq = 1'b1;
            end else begin
                s_nxt.rx_ireq = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.mode <= `CSSP_RST_MODE;
            s_r.ctrl0 <= `CSSP_RST_CTRL0;
            s_r.ti <= 1'b1;
            s_r.steer <= `CSSP_RST_STEER;
            s_r.brg <= `CSSP_RST_BRG;
            s_r.txst <= CSSP_TX_IDLE;
            s_r.txd <= 1'b1;
            s_r.end_of_word_window_d <= 1'b1;
            // idle level of the pin at reset, so no false edge follows
            s_r.ext_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            `CSSP_OFF_MODE: prdata[7:0] = s_r.mode;
            `CSSP_OFF_CTRL0: prdata[7:0] = s_r.ctrl0;
            `CSSP_OFF_CTRL1: prdata[7:0] = {3'h0, s_r.overrun_flag, s_r.rfull,
                s_r.re, s_r.ti, s_r.te};
            `CSSP_OFF_STEER: prdata[7:0] = s_r.steer;
            `CSSP_OFF_BRG: prdata[7:0] = s_r.brg;
            `CSSP_OFF_TXBUF: prdata[7:0] = s_r.txbuf;
            `CSSP_OFF_RXBUF: prdata[7:0] = s_r.rxbuf;
            `CSSP_OFF_IREQ: prdata[1:0] = {s_r.rx_ireq, s_r.tx_ireq};
            default: pslverr = psel && penable;
        endcase
    end

    // pins
    assign sclk = s_r.act ? clock_polarity_bit : idle_lvl;
    assign txd_o = s_r.ctrl0[`CSSP_C0_OD] ? 1'b0 : s_r.txd;
    assign txd_oe = sync_en
        && (s_r.ctrl0[`CSSP_C0_OD] ? !s_r.txd : 1'b1);
    assign main_clock_pin_oe = drive_int;
    assign main_clock_pin_o = sel[1] ? idle_lvl : sclk;
    // alt a only drives its idle level when the port direction allows
    assign alt_clock_pin_a_oe = drive_int && ((sel == 2'b10)
        || (sel[0] && s_r.steer[`CSSP_ST_DIRA]));
    assign alt_clock_pin_a_o = (sel == 2'b10) ? sclk : idle_lvl;
    assign alt_clock_pin_b_oe = drive_int && (sel == 2'b11);
    assign alt_clock_pin_b_o = sclk;
    assign rts_n_o = !(s_r.re && !s_r.ti);
    assign rts_oe = !CH2 && sync_en && hs_on && rts_mode
        && (sel == 2'b00);
    assign tx_irq = s_r.tx_ireq;
    assign rx_irq = s_r.rx_ireq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_word_end: assert property (
        busy && trail && s_r.txcnt == 3'h7 |=> end_of_word_window)
        else $error("word did not end after eight bits");
    chk_ext_clock: assert property (
        sync_en && ext_clk |-> !main_clock_pin_oe)
        else $error("clock pin driven with external clock");
    chk_brg_edge: assert property (
        drive_int && $changed(s_r.act) && !$past(start) |-> $past(brg_tick))
        else $error("shift clock moved without a generator tick");
    chk_start_cond: assert property (
        $rose(busy) |-> $past(s_r.te && !s_r.ti && cts_ok))
        else $error("transmission started without its condition");
    chk_ti_load: assert property (
        $rose(busy) |-> s_r.ti && s_r.tx_ireq)
        else $error("empty flag or request missing at load");
    chk_no_trunc: assert property (
        busy && sync_en && !(trail && s_r.txcnt == 3'h7) |=> busy)
        else $error("word cut short");
    chk_txc_set: assert property (
        sync_en && $rose(end_of_word_window) && !start |=> s_r.ctrl0[3])
        else $error("complete flag not set after window");
    chk_rx_full: assert property (
        rx_done |=> s_r.rfull && s_r.rxbuf == $past(rx_word))
        else $error("received word not placed in buffer");
    chk_overrun: assert property (
        rx_done && s_r.rfull |=> s_r.overrun_flag)
        else $error("overrun flag not set");
    chk_idle_level: assert property (
        drive_int && !busy ##1 !busy |-> main_clock_pin_o == idle_lvl)
        else $error("clock not at idle level");
endmodule : cssp_port
`default_nettype wire

/* verif/cssp_peer.sv */
// Purpose: far-side clock-synchronous port, receives on txd, sends on rxd
// Assumes: shift clock and data pins change only after pclk edges
// Notes: edges are ignored in the cycle in which the polarity changes
`timescale 1ns/1ps
`default_nettype none
module cssp_peer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // serial link
    input wire logic sclk,
    input wire logic sdata_in,
    output logic sdata_out,
    // setup and results
    input wire logic clock_polarity_bit,
    input wire logic [7:0] send_byte,
    output logic [7:0] got_byte,
    output logic [7:0] got_count
);
    logic sclk_r;
    logic cpl_r;
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    wire logic lead;
    wire logic trail;

    // idle level is the inverse of the polarity bit
    // a polarity flip moves the idle level, which is not a clock edge
    assign lead = (cpl_r == clock_polarity_bit) && (sclk_r == ~clock_polarity_bit) && (sclk == clock_polarity_bit);
    assign trail = (cpl_r == clock_polarity_bit) && (sclk_r == clock_polarity_bit)
        && (sclk == ~clock_polarity_bit);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_r <= 1'b1;
            cpl_r <= 1'b0;
            sh_r <= 8'h00;
            bit_r <= 3'h0;
            sdata_out <= 1'b1;
            got_byte <= 8'h00;
            got_count <= 8'h00;
        end else begin
            sclk_r <= sclk;
            cpl_r <= clock_polarity_bit;
            if (lead) begin
                sdata_out <= send_byte[bit_r];
            end
            if (trail) begin
                sh_r <= {sdata_in, sh_r[7:1]};
                bit_r <= bit_r + 3'h1;
                if (bit_r == 3'h7) begin
                    got_byte <= {sdata_in, sh_r[7:1]};
                    got_count <= got_count + 8'h01;
                    // not held after the word, so stale data cannot pass
                    sdata_out <= ~sdata_out;
                end
            end
        end
    end
endmodule : cssp_peer
`default_nettype wire

/* verif/clock_sync_serial_port_tb.sv */
// Purpose: self-checking bench of serial channels 0 and 2 over apb
// Assumes: prescaled tick every cycle, divisor 1, bench drives external clock
// Notes: open-drain txd line has a pull-up here
`timescale 1ns/1ps
`default_nettype none
`include "cssp_cfg.svh"
module clock_sync_serial_port_tb
    import cssp_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic cts_n = 1'b1;
    logic peer_cpl = 1'b0;
    logic [7:0] peer_send = 8'h00;
    logic ext_sclk = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, txd_o, txd_oe, rxd, main_o, main_oe;
    logic rts_n, rts_oe, tx_irq, rx_irq;
    logic alt_a_o, alt_a_oe, alt_b_o, alt_b_oe;
    logic [31:0] prdata2;
    logic rts2_oe;
    wire logic [3:0] steer_pins;
    logic [7:0] peer_byte, peer_count;
    wire logic txd_line;
    wire logic sclk_line;
    int n_errors = 0;
    int checked = 0;

    assign txd_line = txd_oe ? txd_o : 1'b1;
    assign sclk_line = main_oe ? main_o : ext_sclk;
    assign steer_pins = {alt_a_oe, alt_a_o, alt_b_oe, main_o};

    always #5 pclk = ~pclk;

    cssp_port #(.CHANNEL(0)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prescaled_clock(4'hF), .txd_o(txd_o), .txd_oe(txd_oe),
        .rxd_i(rxd), .main_clock_pin_i(sclk_line), .main_clock_pin_o(main_o),
        .main_clock_pin_oe(main_oe), .alt_clock_pin_a_o(alt_a_o),
        .alt_clock_pin_a_oe(alt_a_oe), .alt_clock_pin_b_o(alt_b_o),
        .alt_clock_pin_b_oe(alt_b_oe),
        .cts_n_i(cts_n), .rts_n_o(rts_n), .rts_oe(rts_oe),
        .tx_irq(tx_irq), .rx_irq(rx_irq));

    cssp_peer peer (
        .pclk(pclk), .presetn(presetn), .sclk(sclk_line),
        .sdata_in(txd_line), .sdata_out(rxd), .clock_polarity_bit(peer_cpl),
        .send_byte(peer_send), .got_byte(peer_byte),
        .got_count(peer_count));

    // fixed-format channel on the same bus, seen through its read mux
    cssp_port #(.CHANNEL(2)) DUT2 (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata2), .pready(), .pslverr(),
        .prescaled_clock(4'hF), .txd_o(), .txd_oe(),
        .rxd_i(1'b1), .main_clock_pin_i(1'b1), .main_clock_pin_o(),
        .main_clock_pin_oe(), .alt_clock_pin_a_o(),
        .alt_clock_pin_a_oe(), .alt_clock_pin_b_o(), .alt_clock_pin_b_oe(),
        .cts_n_i(1'b1), .rts_n_o(), .rts_oe(rts2_oe),
        .tx_irq(), .rx_irq());

    task summarize();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t ns: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : check

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] mask,
                input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(q & mask, exp, what);
    endtask : rd_chk

    task wait_words(input logic [7:0] n, input logic [7:0] exp);
        int k;
        k = 0;
        while (peer_count !== n && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        @(posedge pclk);
        check({24'h00_0000, peer_count}, {24'h00_0000, n}, "word count");
        check({24'h00_0000, peer_byte}, {24'h00_0000, exp}, "word data");
    endtask : wait_words

    initial begin
        // bounds a hang: the tests need well under 10k cycles
        #500_000;
        n_errors++;
        $display("Error at %0t ns: watchdog expired", $time);
        summarize();
    end

    initial begin
        logic [31:0] q;
        logic e;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`CSSP_OFF_MODE, 32'hFFFF_FFFF, 32'h0000_0000, "mode");
        rd_chk(`CSSP_OFF_CTRL0, 32'hFFFF_FFFF, 32'h0000_0008, "ctrl0");
        rd_chk(`CSSP_OFF_CTRL1, 32'h0000_001F, 32'h0000_0002, "ctrl1");
        rd_chk(`CSSP_OFF_STEER, 32'hFFFF_FFFF, 32'h0000_0000, "steer");
        apb(1'b0, 8'h40, 32'h0000_0000, q, e);
        check(q, 32'h0000_0000, "unmapped read");
        check({31'h0, e}, 32'h0000_0001, "unmapped error");
        $display("test reset values done");
        // lsb first, push-pull, no handshake, two words back to back
        wr(`CSSP_OFF_MODE, 32'h0000_0001);
        wr(`CSSP_OFF_BRG, 32'h0000_0001);
        wr(`CSSP_OFF_CTRL0, 32'h0000_0010);
        wr(`CSSP_OFF_CTRL1, 32'h0000_0001);
        wr(`CSSP_OFF_TXBUF, 32'h0000_00A5);
        rd_chk(`CSSP_OFF_CTRL1, 32'h0000_0002, 32'h0000_0002, "ti set");
        check({31'h0, main_oe}, 32'h0000_0001, "clock driven");
        check({31'h0, tx_irq}, 32'h0000_0001, "tx request");
        wr(`CSSP_OFF_TXBUF, 32'h0000_005A);
        wait_words(8'h01, 8'hA5);
        wait_words(8'h02, 8'h5A);
        rd_chk(`CSSP_OFF_CTRL0, 32'h0000_0008, 32'h0000_0008, "done");
        wr(`CSSP_OFF_IREQ, 32'h0000_0003);
        @(posedge pclk);
        check({31'h0, tx_irq}, 32'h0000_0000, "tx request cleared");
        $display("test lsb first done");
        // msb first with open-drain driver
        wr(`CSSP_OFF_CTRL0, 32'h0000_00B0);
        @(posedge pclk);
        check(prdata2 & 32'h0000_00E4, 32'h0000_0000, "ch2 fixed");
        wr(`CSSP_OFF_TXBUF, 32'h0000_001E);
        wait_words(8'h03, 8'h78);
        $display("test msb first done");
        // clear-to-send gates the start
        wr(`CSSP_OFF_CTRL0, 32'h0000_0000);
        wr(`CSSP_OFF_TXBUF, 32'h0000_0096);
        repeat (60) @(posedge pclk);
        rd_chk(`CSSP_OFF_CTRL1, 32'h0000_0002, 32'h0000_0000, "held");
        check({24'h0, peer_count}, 32'h0000_0003, "no word");
        cts_n <= 1'b0;
        // cts goes high again while the word is shifting
        repeat (6) @(posedge pclk);
        cts_n <= 1'b1;
        wait_words(8'h04, 8'h96);
        $display("test handshake done");
        // request-to-send, reception, overrun
        wr(`CSSP_OFF_CTRL0, 32'h0000_0004);
        wr(`CSSP_OFF_CTRL1, 32'h0000_0004);
        @(posedge pclk);
        check({31'h0, rts_oe}, 32'h0000_0001, "rts output");
        check({31'h0, rts2_oe}, 32'h0000_0000, "ch2 no rts");
        check({31'h0, rts_n}, 32'h0000_0001, "rts high");
        wr(`CSSP_OFF_TXBUF, 32'h0000_0000);
        @(posedge pclk);
        check({31'h0, rts_n}, 32'h0000_0000, "rts low");
        peer_send <= 8'hC3;
        wr(`CSSP_OFF_CTRL1, 32'h0000_0005);
        wait_words(8'h05, 8'h00);
        rd_chk(`CSSP_OFF_CTRL1, 32'h0000_0018, 32'h0000_0008, "full");
        check({31'h0, rx_irq}, 32'h0000_0001, "rx request");
        wr(`CSSP_OFF_TXBUF, 32'h0000_0000);
        wait_words(8'h06, 8'h00);
        rd_chk(`CSSP_OFF_CTRL1, 32'h0000_0018, 32'h0000_0018, "ovr");
        rd_chk(`CSSP_OFF_RXBUF, 32'h0000_00FF, 32'h0000_00C3, "rx");
        wr(`CSSP_OFF_CTRL1, 32'h0000_0001);
        rd_chk(`CSSP_OFF_CTRL1, 32'h0000_0018, 32'h0000_0000, "clr");
        $display("test receive done");
        // inverted clock polarity
        wr(`CSSP_OFF_CTRL0, 32'h0000_0050);
        peer_cpl <= 1'b1;
        wr(`CSSP_OFF_TXBUF, 32'h0000_006B);
        wait_words(8'h07, 8'h6B);
        $display("test polarity done");
        // clock steering, idle level low with the inverted polarity
        wr(`CSSP_OFF_STEER, 32'h0000_0031);
        @(posedge pclk);
        check({28'h0, steer_pins}, 32'h0000_000A, "steer 11");
        wr(`CSSP_OFF_STEER, 32'h0000_0020);
        @(posedge pclk);
        check({28'h0, steer_pins}, 32'h0000_0008, "steer 10");
        wr(`CSSP_OFF_STEER, 32'h0000_0010);
        @(posedge pclk);
        check({28'h0, steer_pins}, 32'h0000_0000, "steer 01");
        $display("test steering done");
        // external shift clock from the bench, mode bit 3 set
        ext_sclk <= 1'b0;
        wr(`CSSP_OFF_MODE, 32'h0000_0079);
        @(posedge pclk);
        check({31'h0, main_oe}, 32'h0000_0000, "clock input");
        wr(`CSSP_OFF_TXBUF, 32'h0000_003C);
        repeat (8) begin
            repeat (4) @(posedge pclk);
            ext_sclk <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_sclk <= 1'b0;
        end
        wait_words(8'h08, 8'h3C);
        $display("test external clock done");
        summarize();
    end
endmodule : clock_sync_serial_port_tb
`default_nettype wire
